/* hdl/pixel_bias_map_estimator.sv */
// Pixel bias map estimator with APB registers, pixel stream in and buffered stream out.
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/100ps

// Behaviour
// - Each pixel keeps only a 12-bit image word and a 12-bit bias word.
// - Every data exposure, and every bias exposure while the computation runs, overwrites the stored image word of each pixel; raw and histogram exposures do not.
// - First conditioning exposure loads each bias word with the pixel value.
// - Minimum option keeps the smaller of old bias and new pixel.
// - Two-step option replaces bias when pixel is below bias minus T1.
// - Else below bias plus T2 gives C-weighted average; larger leaves bias.
// - After N conditioning exposures, M calibration exposures follow.
// - Calibration pixel above bias plus T3 and its 8 neighbours become 4095.
// - Second pass refines bias by C-average only where image is below 4095.
// - Data images have the bias subtracted on output; the image map keeps the raw word.
// - One rectangular region is either the only region sent or excluded.
// - Histogram mode skips events and bins each pixel value.
// - Full-frame mode passes every pixel that the region lets through, unprocessed, at full rate.
// - One, two, four or six chips can be read out.
module pixel_bias_map_estimator (
	// Clock and reset.
	input  wire logic                CLK_SYS,
	input  wire logic                RST,
	// APB slave.
	input  wire logic                PSEL,
	input  wire logic                PENABLE,
	input  wire logic                PWRITE,
	input  wire logic [7:0]          PADDR,
	input  wire logic [31:0]         PWDATA,
	output logic                     PREADY,
	output logic      [31:0]         PRDATA,
	output logic                     PSLVERR,
	// Pixel stream from the readout.
	input  wire logic                IN_VALID,
	input  wire bias_pkg::pix_in_s   IN_PIX,
	output logic                     IN_READY,
	// Processed pixel stream.
	output logic                     OUT_VALID,
	output bias_pkg::pix_out_s       OUT_PIX,
	input  wire logic                OUT_READY
);
	import bias_pkg::*;

	typedef struct packed {
		mode_e                               mode;
		logic                                opt_two;
		logic                                roi_en;
		logic                                roi_excl;
		logic [CHIP_W-1:0]                   chips;
		logic [PIX_W-1:0]                    t1;
		logic [PIX_W-1:0]                    t2;
		logic [PIX_W-1:0]                    t3;
		logic [7:0]                          c;
		logic [7:0]                          n;
		logic [7:0]                          m;
		logic [COL_W-1:0]                    x0;
		logic [COL_W-1:0]                    x1;
		logic [ROW_W-1:0]                    y0;
		logic [ROW_W-1:0]                    y1;
		logic [3:0]                          hsel;
		phase_e                              phase;
		logic                                done;
		logic [7:0]                          exp_cnt;
		logic [K_W-1:0]                      k;
		logic [HIT_LEN-1:0]                  hits;
		logic [HIST_BINS-1:0][HIST_W-1:0]    hist;
		pix_out_s                            buf0;
		pix_out_s                            buf1;
		logic [1:0]                          buf_cnt;
		logic                                out_valid;
		logic                                in_ready;
		logic                                pready;
		logic [31:0]                         prdata;
		logic                                pslverr;
	} est_s;

	est_s st_r;
	est_s st_nxt;

	// Image and bias maps: the only per-pixel storage.
	logic [PIX_W-1:0] img_mem  [MEM_DEPTH];
	logic [PIX_W-1:0] bias_mem [MEM_DEPTH];

	logic              img_we;
	logic [ADDR_W-1:0] img_wa;
	logic [PIX_W-1:0]  img_wd;
	logic              bias_we;
	logic [ADDR_W-1:0] bias_wa;
	logic [PIX_W-1:0]  bias_wd;

	////////////////////////////////////////////////////////////////////////////////
	// Helper functions.

	// Saturating add within the 12-bit range.
	function automatic logic [PIX_W-1:0] sat_add(input logic [PIX_W-1:0] a,
	                                             input logic [PIX_W-1:0] b);
		logic [PIX_W:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[PIX_W] ? PIX_SAT : s[PIX_W-1:0];
	endfunction

	// Saturating subtract, floored at zero.
	function automatic logic [PIX_W-1:0] sat_sub(input logic [PIX_W-1:0] a,
	                                             input logic [PIX_W-1:0] b);
		return (a > b) ? (a - b) : '0;
	endfunction

	// Running average b + C*(p-b), C being c/256; the step never passes p.
	function automatic logic [PIX_W-1:0] wavg(input logic [PIX_W-1:0] p,
	                                          input logic [PIX_W-1:0] b,
	                                          input logic [7:0]       c);
		logic signed [PIX_W:0]    diff;
		logic signed [PIX_W+9:0]  prod;
		logic signed [PIX_W+1:0]  sum;
		diff = $signed({1'b0, p}) - $signed({1'b0, b});
		prod = diff * $signed({1'b0, c});
		sum  = $signed({2'b00, b}) + $signed(prod[PIX_W+9:8]);
		if (sum < 0) begin
			return '0;
		end else if (sum > $signed({2'b00, PIX_SAT})) begin
			return PIX_SAT;
		end
		return sum[PIX_W-1:0];
	endfunction

	// Mapped, word-aligned register address.
	function automatic logic addr_ok(input logic [7:0] a);
		return (a == OFS_CTRL) || (a == OFS_THR12) || (a == OFS_THR3C) ||
		       (a == OFS_COUNTS) || (a == OFS_ROI_X) || (a == OFS_ROI_Y) ||
		       (a == OFS_STATUS) || (a == OFS_HSEL) || (a == OFS_HDATA);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	// Stream side, sweep side and APB side all fill one copy of the state.
	always_comb begin
		logic              accept;
		logic              pop;
		logic              chip_ok;
		logic              in_roi;
		logic              send;
		logic [ADDR_W-1:0] pa;
		logic [PIX_W-1:0]  pb;
		logic [PIX_W-1:0]  outv;
		logic [K_W-1:0]    total;
		logic [K_W-1:0]    j;
		logic              hit_k;
		logic              any;
		logic [COL_W-1:0]  jc;
		logic [ROW_W-1:0]  jr;
		logic              setup;
		logic              wr;
		logic [31:0]       rd;
		pix_out_s          item;
		st_nxt  = st_r;
		img_we  = 1'b0;
		img_wa  = '0;
		img_wd  = '0;
		bias_we = 1'b0;
		bias_wa = '0;
		bias_wd = '0;
		accept  = IN_VALID && st_r.in_ready;
		pop     = OUT_READY && (st_r.buf_cnt != 2'd0);
		chip_ok = IN_PIX.chip < st_r.chips;
		pa      = {IN_PIX.chip, IN_PIX.row, IN_PIX.col};
		pb      = bias_mem[pa];
		in_roi  = (IN_PIX.col >= st_r.x0) && (IN_PIX.col <= st_r.x1) &&
		          (IN_PIX.row >= st_r.y0) && (IN_PIX.row <= st_r.y1);
		send    = !st_r.roi_en || (in_roi != st_r.roi_excl);
		outv    = IN_PIX.data;
		total   = K_W'({st_r.chips, 8'h00});
		j       = st_r.k - K_W'(COLS + 1);
		jc      = j[COL_W-1:0];
		jr      = j[COL_W+ROW_W-1:COL_W];
		hit_k   = 1'b0;
		any     = 1'b0;
		item    = '0;

		// Output buffer drain: the head leaves, the second entry moves up.
		if (pop) begin
			st_nxt.buf0    = st_r.buf1;
			st_nxt.buf_cnt = st_r.buf_cnt - 2'd1;
		end

		// Accepted pixel, handled by mode.
		if (accept && chip_ok) begin
			img_wa = pa;
			img_wd = IN_PIX.data;
			case (st_r.mode)
				MODE_BIAS: begin
					if (st_r.phase != PH_IDLE) begin
						img_we = 1'b1;
					end
					if (st_r.phase == PH_COND) begin
						bias_wa = pa;
						bias_we = 1'b1;
						if (st_r.exp_cnt == 8'd0) begin
							bias_wd = IN_PIX.data;
						end else if (!st_r.opt_two) begin
							bias_wd = (IN_PIX.data < pb) ? IN_PIX.data : pb;
						end else if (IN_PIX.data < sat_sub(pb, st_r.t1)) begin
							bias_wd = IN_PIX.data;
						end else if (IN_PIX.data < sat_add(pb, st_r.t2)) begin
							bias_wd = wavg(IN_PIX.data, pb, st_r.c);
						end else begin
							bias_wd = pb;
						end
					end
				end
				MODE_HIST: begin
					// Counts stick at full scale rather than wrap.
					if (st_r.hist[IN_PIX.data[11:8]] != '1) begin
						st_nxt.hist[IN_PIX.data[11:8]] =
							st_r.hist[IN_PIX.data[11:8]] + HIST_W'(1);
					end
				end
				MODE_RAW: begin
					send = send;
				end
				default: begin
					img_we = 1'b1;
					outv   = sat_sub(IN_PIX.data, pb);
				end
			endcase
			if ((st_r.mode == MODE_DATA || st_r.mode == MODE_RAW) && send) begin
				item = '{chip: IN_PIX.chip, row: IN_PIX.row, col: IN_PIX.col, data: outv};
				if (st_nxt.buf_cnt == 2'd0) begin
					st_nxt.buf0 = item;
				end else begin
					st_nxt.buf1 = item;
				end
				st_nxt.buf_cnt = st_nxt.buf_cnt + 2'd1;
			end
		end

		// Exposure boundary moves the bias computation along.
		if (accept && IN_PIX.last && st_r.mode == MODE_BIAS) begin
			case (st_r.phase)
				PH_COND: begin
					st_nxt.exp_cnt = st_r.exp_cnt + 8'd1;
					if (st_r.exp_cnt + 8'd1 >= st_r.n) begin
						st_nxt.exp_cnt = 8'd0;
						st_nxt.phase   = (st_r.m == 8'd0) ? PH_IDLE : PH_CAL;
						st_nxt.done    = (st_r.m == 8'd0);
					end
				end
				PH_CAL: begin
					st_nxt.phase = PH_SWEEP;
					st_nxt.k     = '0;
					st_nxt.hits  = '0;
				end
				default: begin
					st_nxt.phase = st_r.phase;
				end
			endcase
		end

		// Sweep: detect at k, settle pixel j one row and one column behind,
		// so all eight neighbours of j have been judged against the raw image.
		if (st_r.phase == PH_SWEEP) begin
			if (st_r.k < total) begin
				hit_k = img_mem[st_r.k[ADDR_W-1:0]] >
				        sat_add(bias_mem[st_r.k[ADDR_W-1:0]], st_r.t3);
			end
			st_nxt.hits = {st_r.hits[HIT_LEN-2:0], hit_k};
			if (st_r.k >= K_W'(COLS + 1)) begin
				any = st_nxt.hits[COLS+1];
				if (jc != '0) begin
					any = any || st_nxt.hits[COLS+2];
					any = any || (jr != '0 && st_nxt.hits[2*COLS+2]);
					any = any || (jr != ROW_W'(ROWS-1) && st_nxt.hits[2]);
				end
				if (jc != COL_W'(COLS-1)) begin
					any = any || st_nxt.hits[COLS];
					any = any || (jr != '0 && st_nxt.hits[2*COLS]);
					any = any || (jr != ROW_W'(ROWS-1) && st_nxt.hits[0]);
				end
				any = any || (jr != '0 && st_nxt.hits[2*COLS+1]);
				any = any || (jr != ROW_W'(ROWS-1) && st_nxt.hits[1]);
				img_wa  = j[ADDR_W-1:0];
				bias_wa = j[ADDR_W-1:0];
				img_wd  = PIX_SAT;
				if (any) begin
					img_we = 1'b1;
				end else if (img_mem[j[ADDR_W-1:0]] < PIX_SAT) begin
					bias_we = 1'b1;
					bias_wd = wavg(img_mem[j[ADDR_W-1:0]], bias_mem[j[ADDR_W-1:0]], st_r.c);
				end
			end
			st_nxt.k = st_r.k + K_W'(1);
			if (st_r.k == total + K_W'(COLS)) begin
				st_nxt.exp_cnt = st_r.exp_cnt + 8'd1;
				st_nxt.phase   = PH_CAL;
				if (st_r.exp_cnt + 8'd1 >= st_r.m) begin
					st_nxt.phase = PH_IDLE;
					st_nxt.done  = 1'b1;
				end
			end
		end

		// APB: answer in the cycle after setup, writes land at that access edge.
		setup = PSEL && !PENABLE;
		wr    = PSEL && PENABLE && PWRITE && st_r.pready;
		rd    = '0;
		case (PADDR)
			OFS_CTRL:   rd = {21'h0, st_r.chips, 2'b00, st_r.roi_en, st_r.roi_excl,
			                  st_r.opt_two, 1'b0, st_r.mode};
			OFS_THR12:  rd = {4'h0, st_r.t2, 4'h0, st_r.t1};
			OFS_THR3C:  rd = {8'h0, st_r.c, 4'h0, st_r.t3};
			OFS_COUNTS: rd = {16'h0, st_r.m, st_r.n};
			OFS_ROI_X:  rd = {20'h0, st_r.x1, 4'h0, st_r.x0};
			OFS_ROI_Y:  rd = {20'h0, st_r.y1, 4'h0, st_r.y0};
			OFS_STATUS: rd = {16'h0, st_r.exp_cnt, 5'h0, st_r.done, st_r.phase};
			OFS_HSEL:   rd = {28'h0, st_r.hsel};
			OFS_HDATA:  rd = {16'h0, st_r.hist[st_r.hsel]};
			default:    rd = '0;
		endcase
		st_nxt.pready  = setup;
		st_nxt.pslverr = setup && (!addr_ok(PADDR) || PADDR[1:0] != 2'b00);
		st_nxt.prdata  = (setup && !PWRITE && addr_ok(PADDR)) ? rd : '0;
		if (wr) begin
			case (PADDR)
				OFS_CTRL: begin
					st_nxt.mode     = mode_e'(PWDATA[1:0]);
					st_nxt.opt_two  = PWDATA[CTRL_OPT];
					st_nxt.roi_excl = PWDATA[CTRL_EXCL];
					st_nxt.roi_en   = PWDATA[CTRL_ROI];
					// Only the supported chip counts are taken; others keep the old one.
					if (PWDATA[CTRL_CHIPS+:CHIP_W] inside {3'd1, 3'd2, 3'd4, 3'd6}) begin
						st_nxt.chips = PWDATA[CTRL_CHIPS+:CHIP_W];
					end
					if (PWDATA[CTRL_START]) begin
						st_nxt.done    = 1'b0;
						st_nxt.exp_cnt = 8'd0;
						st_nxt.hist    = '0;
						st_nxt.phase   = PH_IDLE;
						if (mode_e'(PWDATA[1:0]) == MODE_BIAS) begin
							st_nxt.phase = (st_r.n == 8'd0) ? PH_CAL : PH_COND;
						end
					end
				end
				OFS_THR12: begin
					st_nxt.t1 = PWDATA[PIX_W-1:0];
					st_nxt.t2 = PWDATA[THR_HI+:PIX_W];
				end
				OFS_THR3C: begin
					st_nxt.t3 = PWDATA[PIX_W-1:0];
					st_nxt.c  = PWDATA[THR_HI+:8];
				end
				OFS_COUNTS: begin
					st_nxt.n = PWDATA[7:0];
					st_nxt.m = PWDATA[15:8];
				end
				OFS_ROI_X: begin
					st_nxt.x0 = PWDATA[COL_W-1:0];
					st_nxt.x1 = PWDATA[8+:COL_W];
				end
				OFS_ROI_Y: begin
					st_nxt.y0 = PWDATA[ROW_W-1:0];
					st_nxt.y1 = PWDATA[8+:ROW_W];
				end
				OFS_HSEL: begin
					st_nxt.hsel = PWDATA[3:0];
				end
				default: begin
					st_nxt.hsel = st_nxt.hsel;
				end
			endcase
		end

		// Ready only with room for one more word and no sweep running.
		st_nxt.in_ready = (st_nxt.buf_cnt < 2'(BUF_DEPTH)) && (st_nxt.phase != PH_SWEEP);
		st_nxt.out_valid = st_nxt.buf_cnt != 2'd0; // Own flop, so the pin is glitch free.
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register.

	// All control state resets to constants; maps are left as they are.
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			st_r          <= '0;
			st_r.mode     <= MODE_DATA;
			st_r.phase    <= PH_IDLE;
			st_r.chips    <= RST_CHIPS;
			st_r.t1       <= RST_T1;
			st_r.t2       <= RST_T2;
			st_r.t3       <= RST_T3;
			st_r.c        <= RST_C;
			st_r.n        <= RST_N;
			st_r.m        <= RST_M;
			st_r.x1       <= COL_W'(COLS - 1);
			st_r.y1       <= ROW_W'(ROWS - 1);
		end else begin
			st_r <= st_nxt;
		end
	end

	// Map writes: one image word and one bias word per cycle at most.
	always_ff @(posedge CLK_SYS) begin
		if (img_we) begin
			img_mem[img_wa] <= img_wd;
		end
		if (bias_we) begin
			bias_mem[bias_wa] <= bias_wd;
		end
	end

	// Outputs straight from the state register.
	assign PREADY    = st_r.pready;
	assign PRDATA    = st_r.prdata;
	assign PSLVERR   = st_r.pslverr;
	assign IN_READY  = st_r.in_ready;
	assign OUT_VALID = st_r.out_valid;
	assign OUT_PIX   = st_r.buf0;

endmodule

/* pkg/bias_pkg.sv */
// Package with constants, modes and carriers for the pixel bias map estimator.
package bias_pkg;

	// Pixel geometry: one chip frame is ROWS x COLS words, up to 6 frames.
	localparam int           PIX_W      = 12;
	localparam logic [11:0]  PIX_SAT    = 12'hFFF;
	localparam int           COLS       = 16;
	localparam int           ROWS       = 16;
	localparam int           COL_W      = 4;
	localparam int           ROW_W      = 4;
	localparam int           CHIP_W     = 3;
	localparam int           ADDR_W     = CHIP_W + ROW_W + COL_W;
	localparam int           MEM_DEPTH  = 6 * ROWS * COLS;
	localparam int           K_W        = 12;
	localparam int           HIT_LEN    = 2 * COLS + 3;
	localparam int           HIST_BINS  = 16;
	localparam int           HIST_W     = 16;
	localparam int           BUF_DEPTH  = 2;

	// Register offsets (byte addresses on APB).
	localparam logic [7:0]   OFS_CTRL   = 8'h00;
	localparam logic [7:0]   OFS_THR12  = 8'h04;
	localparam logic [7:0]   OFS_THR3C  = 8'h08;
	localparam logic [7:0]   OFS_COUNTS = 8'h0C;
	localparam logic [7:0]   OFS_ROI_X  = 8'h10;
	localparam logic [7:0]   OFS_ROI_Y  = 8'h14;
	localparam logic [7:0]   OFS_STATUS = 8'h18;
	localparam logic [7:0]   OFS_HSEL   = 8'h1C;
	localparam logic [7:0]   OFS_HDATA  = 8'h20;

	// Field positions.
	localparam int           CTRL_START = 2;
	localparam int           CTRL_OPT   = 3;
	localparam int           CTRL_EXCL  = 4;
	localparam int           CTRL_ROI   = 5;
	localparam int           CTRL_CHIPS = 8;
	localparam int           THR_HI     = 16;

	// Values after reset.
	localparam logic [11:0]  RST_T1     = 12'h0_010;
	localparam logic [11:0]  RST_T2     = 12'h0_010;
	localparam logic [11:0]  RST_T3     = 12'h0_020;
	localparam logic [7:0]   RST_C      = 8'h20;
	localparam logic [7:0]   RST_N      = 8'h08;
	localparam logic [7:0]   RST_M      = 8'h08;
	localparam logic [2:0]   RST_CHIPS  = 3'h1;

	typedef enum logic [1:0] {
		MODE_DATA = 2'b00,
		MODE_BIAS = 2'b01,
		MODE_HIST = 2'b10,
		MODE_RAW  = 2'b11
	} mode_e;

	typedef enum logic [1:0] {
		PH_IDLE  = 2'b00,
		PH_COND  = 2'b01,
		PH_CAL   = 2'b10,
		PH_SWEEP = 2'b11
	} phase_e;

	typedef struct packed {
		logic              last;
		logic [CHIP_W-1:0] chip;
		logic [ROW_W-1:0]  row;
		logic [COL_W-1:0]  col;
		logic [PIX_W-1:0]  data;
	} pix_in_s;

	typedef struct packed {
		logic [CHIP_W-1:0] chip;
		logic [ROW_W-1:0]  row;
		logic [COL_W-1:0]  col;
		logic [PIX_W-1:0]  data;
	} pix_out_s;

endpackage

/* verif/pbme_chk.sv */
// Port-level assertions for the pixel bias map estimator.
`timescale 1ns/100ps
module pbme_chk (
	// Clock and reset.
	input wire logic               CLK_SYS,
	input wire logic               RST,
	// APB.
	input wire logic               PSEL,
	input wire logic               PENABLE,
	input wire logic               PWRITE,
	input wire logic [7:0]         PADDR,
	input wire logic [31:0]        PWDATA,
	input wire logic               PREADY,
	input wire logic [31:0]        PRDATA,
	input wire logic               PSLVERR,
	// Pixel streams.
	input wire logic               IN_VALID,
	input wire bias_pkg::pix_in_s  IN_PIX,
	input wire logic               IN_READY,
	input wire logic               OUT_VALID,
	input wire bias_pkg::pix_out_s OUT_PIX,
	input wire logic               OUT_READY
);
	import bias_pkg::*;
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RST);
	////////////////////////////////////////
	// A setup cycle, and an output word held back by the receiver.
	sequence s_setup;
		PSEL && !PENABLE;
	endsequence
	sequence s_held;
		OUT_VALID && !OUT_READY;
	endsequence
	// Zero wait states: one ready pulse per setup, never a stray one.
	property p_rdy_next;
		s_setup |=> PREADY;
	endproperty
	property p_rdy_once;
		PREADY |=> !PREADY;
	endproperty
	property p_rdy_cause;
		PREADY |-> $past(PSEL) && !$past(PENABLE);
	endproperty
	// An error answer carries no data, and idle read data stays zero.
	property p_err_data;
		PSLVERR |-> PREADY && PRDATA == 32'h0000_0000;
	endproperty
	property p_rdata_idle;
		!PREADY |-> PRDATA == 32'h0000_0000;
	endproperty
	// Unaligned words are refused; mapped words are not.
	property p_unaligned;
		s_setup ##0 PADDR[1:0] != 2'b00 |=> PSLVERR;
	endproperty
	property p_mapped;
		s_setup ##0 (PADDR <= OFS_HDATA && PADDR[1:0] == 2'b00) |=> !PSLVERR;
	endproperty
	// A word the receiver has not taken stays, unchanged, into the next cycle.
	property p_out_keep;
		s_held |=> OUT_VALID && $stable(OUT_PIX) ##1 (OUT_VALID || $past(OUT_READY));
	endproperty
	a_rdy_next: assert property (p_rdy_next) else $error("setup not answered");
	a_rdy_once: assert property (p_rdy_once) else $error("ready too long");
	a_rdy_cause: assert property (p_rdy_cause) else $error("ready w/o setup");
	a_err_data: assert property (p_err_data) else $error("error with data");
	a_rdata_idle: assert property (p_rdata_idle) else $error("idle data");
	a_unaligned: assert property (p_unaligned) else $error("unaligned taken");
	a_mapped: assert property (p_mapped) else $error("mapped refused");
	a_out_keep: assert property (p_out_keep) else $error("held word lost");
endmodule

bind pixel_bias_map_estimator pbme_chk i_pbme_chk (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
	.PRDATA(PRDATA), .PSLVERR(PSLVERR), .IN_VALID(IN_VALID), .IN_PIX(IN_PIX),
	.IN_READY(IN_READY), .OUT_VALID(OUT_VALID), .OUT_PIX(OUT_PIX), .OUT_READY(OUT_READY));

/* verif/readout_model.sv */
// Readout-side model: plays one exposure of chip 0 into the estimator.
`timescale 1ns/100ps
module readout_model (
	// Clock.
	input  wire logic        clk,
	// Pixel stream.
	input  wire logic        in_ready,
	output logic             in_valid,
	output bias_pkg::pix_in_s in_pix
);
	import bias_pkg::*;
	logic [PIX_W-1:0] frm [ROWS*COLS];
	int               gap;
	// Idle at time zero.
	initial begin
		in_valid = 1'b0;
		in_pix = '0;
		gap = 0;
	end
	// Each word is held until taken; when gap is nonzero, the lines toggle between words so that
	// stale data can never pass for a real word.
	task automatic play();
		@(posedge clk);
		for (int i = 0; i < ROWS*COLS; i++) begin
			in_valid <= 1'b1;
			in_pix <= {i == ROWS*COLS-1, 3'h0, 8'(i), frm[i]};
			do @(posedge clk); while (in_ready !== 1'b1);
			if (gap != 0) begin
				in_valid <= 1'b0;
				in_pix <= ~in_pix;
				repeat (gap) @(posedge clk);
			end
		end
		in_valid <= 1'b0;
		in_pix <= ~in_pix;
	endtask
endmodule

/* verif/tb.sv */
// Self-checking bench for the pixel bias map estimator.
`timescale 1ns/100ps
module tb;
	import bias_pkg::*;
	// Design-facing signals; all that the bench drives are defined at time zero.
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic        in_valid;
	pix_in_s     in_pix;
	logic        in_ready;
	logic        out_valid;
	pix_out_s    out_pix;
	logic        out_ready = 1'b0;
	// Bench state.
	logic        stall = 1'b0;
	logic [2:0]  tick = 3'h0;
	logic [31:0] seed = 32'h0000_725A;
	logic [31:0] q;
	logic        e;
	logic [11:0] bias [ROWS*COLS];
	pix_out_s    expq [$];
	int          fail_count = 0;
	int          checks_done = 0;
	logic [7:0]  ra [7] = '{OFS_CTRL, OFS_THR12, OFS_THR3C, OFS_COUNTS, OFS_ROI_X,
		OFS_ROI_Y, 8'h24};
	logic [31:0] rv [7] = '{{21'h0, RST_CHIPS, 8'h00}, {4'h0, RST_T2, 4'h0, RST_T1},
		{8'h00, RST_C, 4'h0, RST_T3}, {16'h0000, RST_M, RST_N}, 32'h0000_0F00,
		32'h0000_0F00, 32'h0000_0000};
	////////////////////////////////////////
	always #12.5 clk_sys = ~clk_sys;
	pixel_bias_map_estimator i_pixel_bias_map_estimator (.CLK_SYS(clk_sys), .RST(rst),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .IN_VALID(in_valid),
		.IN_PIX(in_pix), .IN_READY(in_ready), .OUT_VALID(out_valid), .OUT_PIX(out_pix),
		.OUT_READY(out_ready));
	readout_model i_readout_model (.clk(clk_sys), .in_ready(in_ready), .in_valid(in_valid),
		.in_pix(in_pix));
	////////////////////////////////////////
	// Xorshift source, so every run draws the same pixels.
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Running average b + (p - b) * C / 256, rounded towards minus infinity.
	function automatic logic [11:0] wavg(input logic [11:0] b, input logic [11:0] p);
		logic signed [23:0] t;
		t = ($signed({12'h000, p}) - $signed({12'h000, b})) * $signed({16'h0000, RST_C});
		return b + 12'(t >>> 8);
	endfunction
	// One conditioning step; the bounds saturate inside 12 bits.
	function automatic logic [11:0] upd(input bit first, input logic opt,
		input logic [11:0] b, input logic [11:0] p);
		logic [11:0] lo;
		logic [11:0] hi;
		lo = (b > RST_T1) ? b - RST_T1 : 12'h000;
		hi = (b > 12'hFFF - RST_T2) ? 12'hFFF : b + RST_T2;
		if (first) return p;
		if (!opt) return (p < b) ? p : b;
		if (p < lo) return p;
		if (p < hi) return wavg(b, p);
		return b;
	endfunction
	// Dark levels with a few high events and a few low outliers.
	function automatic logic [11:0] cval();
		logic [31:0] r;
		r = rnd();
		if (r[11:8] == 4'h0) return 12'h400;
		if (r[11:8] == 4'h1) return 12'h0C0;
		return 12'h100 + 12'(r[5:0]);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One APB transfer; the request holds until ready is sampled high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		chk({31'h0, pready}, 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic drain();
		for (int k = 0; k < 2000 && expq.size() != 0; k++) @(posedge clk_sys);
		chk(32'(expq.size()), 32'h0);
	endtask
	////////////////////////////////////////
	// Receiver stalls one cycle in eight, longer on request; words match in order.
	always @(posedge clk_sys) begin
		tick <= tick + 3'h1;
		out_ready <= !stall && tick != 3'h3;
		if (!rst && out_valid === 1'b1 && out_ready === 1'b1) begin
			if (expq.size() == 0) chk(32'(out_pix), 32'hFFFF_FFFF);
			else chk(32'(out_pix), 32'(expq.pop_front())); // Output word
		end
	end
	// Raw frame through a long stall: the buffer must refuse, not drop.
	task automatic raw_frame();
		apb(1'b1, OFS_ROI_X, 32'h0000_0D02);
		apb(1'b1, OFS_CTRL, {21'h0, RST_CHIPS, 8'h23});
		for (int i = 0; i < 256; i++) begin
			i_readout_model.frm[i] = 12'(rnd());
			if (i[3:0] inside {[2:13]}) // Columns 2 to 13 only
				expq.push_back({3'h0, 8'(i), i_readout_model.frm[i]});
		end
		stall <= 1'b1;
		fork
			i_readout_model.play();
			begin
				repeat (24) @(posedge clk_sys);
				stall <= 1'b0;
			end
		join
		drain();
	endtask
	// N conditioning and M calibration exposures, with a hot pixel at row 5, column 5.
	task automatic bias_run(input logic opt, input logic [7:0] n, input logic [7:0] m);
		apb(1'b1, OFS_COUNTS, {16'h0000, m, n});
		apb(1'b0, OFS_COUNTS, 32'h0);
		chk(q, {16'h0000, m, n}); // Counts read back
		apb(1'b1, OFS_CTRL, {21'h0, RST_CHIPS, 4'h0, opt, 3'b101});
		i_readout_model.gap = int'(opt);
		for (int f = 0; f < n + m; f++) begin
			for (int i = 0; i < 256; i++) begin
				if (f < n) i_readout_model.frm[i] = cval();
				else i_readout_model.frm[i] = (i == 8'h55) ? 12'h800 : bias[i] + 12'h010;
			end
			i_readout_model.play();
			for (int i = 0; i < 256; i++) begin
				if (f < n) bias[i] = upd(f == 0, opt, bias[i], i_readout_model.frm[i]);
				else if (!(i[7:4] inside {[4:6]} && i[3:0] inside {[4:6]}))
					bias[i] = wavg(bias[i], i_readout_model.frm[i]); // Event mask
			end
		end
		for (int k = 0; k < 500; k++) begin
			apb(1'b0, OFS_STATUS, 32'h0);
			if (q[2] === 1'b1) break;
		end
		chk({29'h0, q[2:0]}, 32'h0000_0004); // Idle and done
	endtask
	// Data frame: each word leaves with its bias removed, clipped at zero.
	task automatic data_frame();
		logic [31:0] r;
		logic [11:0] p;
		apb(1'b1, OFS_CTRL, {21'h0, RST_CHIPS, 8'h00});
		for (int i = 0; i < 256; i++) begin
			r = rnd();
			p = (r[13:12] == 2'b00) ? 12'(r[5:0]) : 12'h800 + 12'(r[7:0]);
			i_readout_model.frm[i] = p;
			expq.push_back({3'h0, 8'(i), (p > bias[i]) ? p - bias[i] : 12'h000});
		end
		i_readout_model.play();
		drain();
	endtask
	// Histogram: every pixel counts once in the bin of its top four bits.
	task automatic hist_frame();
		int hc [16];
		apb(1'b1, OFS_CTRL, {21'h0, RST_CHIPS, 8'h06});
		for (int i = 0; i < 256; i++) hc[i_readout_model.frm[i][11:8]]++;
		i_readout_model.play();
		for (int b = 0; b < 16; b++) begin
			apb(1'b1, OFS_HSEL, 32'(b));
			apb(1'b0, OFS_HDATA, 32'h0);
			chk(q, 32'(hc[b])); // Bin count
		end
	endtask
	task automatic final_report();
		if (fail_count == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////
	// Main sequence: reset values, refusals, raw, both options, calibration.
	initial begin
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, ra[i], 32'h0);
			chk(q, rv[i]); // Reset value
			chk({31'h0, e}, {31'h0, i == 6});
		end
		apb(1'b1, 8'h02, 32'hFFFF_FFFF);
		chk({31'h0, e}, 32'h1);
		apb(1'b0, OFS_CTRL, 32'h0);
		chk(q, rv[0]);
		raw_frame();
		bias_run(1'b0, 8'h03, 8'h00);
		data_frame();
		bias_run(1'b1, 8'h03, 8'h00);
		data_frame();
		bias_run(1'b0, 8'h01, 8'h02);
		data_frame();
		hist_frame();
		final_report();
	end
	// A hang ends the run as a mismatch.
	initial begin
		repeat (60000) @(posedge clk_sys);
		fail_count++;
		final_report();
	end
endmodule
